// >>> src/mio_pkg.sv
// Package for the module pin multiplexer, general outputs and LED logic.
// Assumes a single 25 MHz core clock shared by every file of the block.
package mio_pkg;

   // Core clock rate
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned CLK_PER_MS    = CLK_HZ / 1000;

   // LED timing in its own unit, then in cycles
   localparam int unsigned BLINK_OFF_MS  = 100;
   localparam int unsigned BLINK_ALT_MS  = 50;
   localparam int unsigned HOLD_ON_MS    = 5000;
   localparam int unsigned BLINK_CYC     = BLINK_OFF_MS * CLK_PER_MS;
   localparam int unsigned BLINK_ALT_CYC = BLINK_ALT_MS * CLK_PER_MS;
   localparam int unsigned HOLD_ON_CYC   = HOLD_ON_MS * CLK_PER_MS;

   // Alarm pin source selector codes
   localparam logic [1:0] SEL_NORMAL  = 2'h0;
   localparam logic [1:0] SEL_LINKACT = 2'h1;
   localparam logic [1:0] SEL_GPO     = 2'h2;
   localparam logic [1:0] SEL_RSVD    = 2'h3;

   // Transmit LED mode codes
   localparam logic [1:0] LED_COMBO   = 2'h0;
   localparam logic [1:0] LED_LINK    = 2'h1;
   localparam logic [1:0] LED_ACT     = 2'h2;
   localparam logic [1:0] LED_OFF     = 2'h3;

   // Values after reset
   localparam logic [2:0] MS_RST      = 3'h0;
   localparam logic       DIV64_RST   = 1'b1;

   // Management configuration bits
   typedef struct packed {
      logic       ctrl_b_sel;        // 0 reset/tx-disable, 1 interrupt B
      logic [1:0] ctrl_out_b_polarity;
      logic       alarm_sel;         // 0 normal, 1 general output
      logic       alarm_gpo_value;
      logic       alarm_enable;
      logic [1:0] rx_sel;
      logic       rx_alarm_gpo_value;
      logic [1:0] tx_sel;
      logic       tx_alarm_gpo_value;
      logic [1:0] tx_led_mode;
      logic       tx_blink_alt;
      logic       tx_alarm_live;     // 1 disables clear-on-read
      logic       mc_override;
      logic [2:0] mc_value;
      logic [2:0] ms_mask;
      logic       serial_tx_invert;
      logic       div64_disable;
   } mio_cfg_t;

endpackage

// >>> src/mio_led.sv
// Link/activity LED sequencer: hold-on, steady and blink phases.
// Assumes link and activity inputs come from logic on the same clock.
module mio_led import mio_pkg::*; #(
   parameter int unsigned HOLD_CYC = HOLD_ON_CYC,
   parameter int unsigned ON_CYC   = BLINK_CYC,
   parameter int unsigned ALT_CYC  = BLINK_ALT_CYC
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   // Link state and activity
   input  wire logic link_in,
   input  wire logic act_in,
   input  wire logic alt_in,
   // LED state, 1 means lit; blink_out 1 while blinking
   output logic      led_out,
   output logic      blink_out
);

   localparam int unsigned MAXP = (ON_CYC > ALT_CYC) ? ON_CYC : ALT_CYC;
   localparam int unsigned HW   = $clog2(HOLD_CYC + 1);
   localparam int unsigned BW   = $clog2(MAXP + 1);

   logic [HW-1:0] hold_q;
   logic [BW-1:0] tick_q;
   logic [BW-1:0] period;
   logic          hold_done;
   logic          tick;
   logic          act_q;

   // Phase length; on-time equals off-time
   assign period    = alt_in ? BW'(ALT_CYC - 1) : BW'(ON_CYC - 1);
   assign tick      = (tick_q >= period);
   assign hold_done = (hold_q == HW'(HOLD_CYC));

   // Initial hold-on counter, restarts on every link loss
   always_ff @(posedge clk_in) begin
      if (!nrst_in || !link_in) begin
         hold_q <= '0;
      end else if (!hold_done) begin
         hold_q <= hold_q + 1'b1;
      end
   end

   // Blink prescaler
   always_ff @(posedge clk_in) begin
      if (!nrst_in || !link_in) begin
         tick_q <= '0;
      end else if (tick) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + 1'b1;
      end
   end

   // Activity seen in this phase; a start char at the tick is kept
   always_ff @(posedge clk_in) begin
      if (!nrst_in || !link_in) begin
         act_q <= 1'b0;
      end else if (act_in) begin
         act_q <= 1'b1;
      end else if (tick) begin
         act_q <= 1'b0;
      end
   end

   // LED: link down wins over hold and activity
   always_ff @(posedge clk_in) begin
      if (!nrst_in || !link_in) begin
         led_out   <= 1'b0;
         blink_out <= 1'b0;
      end else if (!hold_done) begin
         led_out   <= 1'b1;
         blink_out <= 1'b0;
      end else if (tick) begin
         led_out   <= !led_out || !act_q;
         blink_out <= act_q;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_led_link_down;
      !link_in |=> !led_out;
   endproperty
   a_led_link_down: assert property (p_led_link_down)
      else $error("LED lit while link down");

   property p_led_hold;
      link_in && !hold_done |=> led_out;
   endproperty
   a_led_hold: assert property (p_led_hold)
      else $error("LED dark during hold-on time");

   property p_led_steady;
      link_in && hold_done && !act_q && !act_in && led_out |=> led_out;
   endproperty
   a_led_steady: assert property (p_led_steady)
      else $error("LED left steady state without activity");

   c_led_blink_off: cover property (link_in && $fell(led_out));
   c_led_hold_end: cover property ($rose(hold_done));

endmodule

// >>> src/mio_top.sv
// Pin multiplexer for module control/status pins, general outputs and
// link/activity LEDs. Assumes config bits come from a management block
// on the same clock; pin inputs are asynchronous and synchronised here.
// Open-drain outputs are given as enables: high pulls the line low.

// Operation
// - Output B selects reset or interrupt B
// - Output B polarity invertible before driver
// - Alarm-status selects normal or general output
// - Normal alarm-status off until enabled
// - Receive selector: normal, LED, output, reserved
// - Receive selector 10 drives dedicated value
// - Transmit selector: normal, LED, output, reserved
// - Transmit selector 10 drives dedicated value
// - Transmit alarm clears on read by default
// - Transmit LED mode and blink-time controls
// - Receive: start chars activity, block lock link
// - Receive LED off, steady, or blinking
// - Transmit: start chars activity, lanes aligned link
// - Transmit LED off, steady, or blinking
// - LED held on up to five seconds
// - Link down forces LED off
// - Same LED behaviour for both coding modes
// - Override takes master code from registers
// - Status pins set pending, maskable, readable
// - Serial transmit polarity programmable
// - Divided reference clock enabled, pin or bit disable
// - Outputs are open-drain pull-low
// - Global alarm interrupt is open-drain
module mio_top import mio_pkg::*; #(
   parameter int unsigned HOLD_CYCLES      = HOLD_ON_CYC,
   parameter int unsigned BLINK_CYCLES     = BLINK_CYC,
   parameter int unsigned BLINK_ALT_CYCLES = BLINK_ALT_CYC
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // Management configuration and strobes
   input  wire mio_cfg_t   cfg_in,
   input  wire logic       tx_alarm_read_in,
   input  wire logic [2:0] ms_pending_clr_in,
   // Internal function sources
   input  wire logic       module_reset_in,
   input  wire logic       wis_int_b_in,
   input  wire logic       alarm_src_in,
   input  wire logic       rx_alarm_src_in,
   input  wire logic       tx_alarm_src_in,
   input  wire logic       alarm_irq_src_in,
   // Datapath link and activity indications
   input  wire logic       pcs_block_lock_in,
   input  wire logic       rx_start_char_in,
   input  wire logic       lanes_aligned_in,
   input  wire logic       tx_start_char_in,
   // Asynchronous pins
   input  wire logic [2:0] hs_master_code_pins_in,
   input  wire logic       optical_loss_in,
   input  wire logic       div64_ref_enable_pin_in,
   // Open-drain pin enables
   output logic            module_ctrl_out_b_oe_out,
   output logic            alarm_status_oe_out,
   output logic            rx_alarm_oe_out,
   output logic            tx_alarm_oe_out,
   output logic            global_alarm_irq_oe_out,
   // Status and control toward other blocks
   output logic [2:0]      hs_master_code_out,
   output logic [2:0]      ms_pending_out,
   output logic [2:0]      ms_level_out,
   output logic            optical_loss_out,
   output logic            tx_alarm_flag_out,
   output logic            serial_tx_invert_out,
   output logic            div64_ref_out_en_out
);

   // Level presented on an alarm pin for a given selector
   function automatic logic pin_level(input logic [1:0] sel,
                                      input logic       normal,
                                      input logic       led_lit,
                                      input logic       general_output);
      logic lvl;
      lvl = 1'b1;
      unique case (sel)
         SEL_NORMAL:  lvl = normal;
         SEL_LINKACT: lvl = !led_lit;
         SEL_GPO:     lvl = general_output;
         SEL_RSVD:    lvl = 1'b1; // Reserved code releases the line
      endcase
      return lvl;
   endfunction

   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] ms_prev_q;
   logic [1:0] aux_s1_q;
   logic [1:0] aux_s2_q;
   logic       tx_alarm_hold_q;
   logic       rx_led;
   logic       tx_led;
   logic       tx_blink;
   logic       tx_led_lit;
   logic       ctrl_b_lvl;
   logic       alarm_lvl;
   logic       rx_lvl;
   logic       tx_lvl;
   logic       tx_normal;

   // Two-stage synchronisers for all asynchronous pins
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         pin_s1_q <= MS_RST;
         pin_s2_q <= MS_RST;
         aux_s1_q <= 2'h0;
         aux_s2_q <= 2'h0;
      end else begin
         pin_s1_q <= hs_master_code_pins_in;
         pin_s2_q <= pin_s1_q;
         aux_s1_q <= {div64_ref_enable_pin_in, optical_loss_in};
         aux_s2_q <= aux_s1_q;
      end
   end

   // Master code from registers or from the synchronised pins
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         hs_master_code_out <= MS_RST;
      end else begin
         hs_master_code_out <= cfg_in.mc_override ? cfg_in.mc_value
                                                  : pin_s2_q;
      end
   end

   // Status pins: any level change sets pending; set beats clear
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ms_prev_q      <= MS_RST;
         ms_pending_out <= MS_RST;
         ms_level_out   <= MS_RST;
      end else begin
         ms_prev_q      <= pin_s2_q;
         ms_pending_out <= (ms_pending_out & ~ms_pending_clr_in)
                           | (pin_s2_q ^ ms_prev_q);
         ms_level_out   <= pin_s2_q;
      end
   end

   // Pin status and fixed-function controls
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         optical_loss_out     <= 1'b0;
         serial_tx_invert_out <= 1'b0;
         div64_ref_out_en_out <= DIV64_RST;
      end else begin
         optical_loss_out     <= aux_s2_q[0];
         serial_tx_invert_out <= cfg_in.serial_tx_invert;
         div64_ref_out_en_out <= aux_s2_q[1]
                                 && !cfg_in.div64_disable;
      end
   end

   // Transmit alarm latch; a new alarm in the read cycle survives
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         tx_alarm_hold_q <= 1'b0;
      end else begin
         tx_alarm_hold_q <= tx_alarm_src_in
                            || (tx_alarm_hold_q && !tx_alarm_read_in);
      end
   end
   assign tx_normal = cfg_in.tx_alarm_live ? tx_alarm_src_in
                                           : tx_alarm_hold_q;

   // LED sequencers; coding mode is not an input on purpose
   mio_led #(
      .HOLD_CYC (HOLD_CYCLES),
      .ON_CYC   (BLINK_CYCLES),
      .ALT_CYC  (BLINK_ALT_CYCLES)
   ) u_rx_led (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .link_in   (pcs_block_lock_in),
      .act_in    (rx_start_char_in),
      .alt_in    (1'b0),
      .led_out   (rx_led),
      .blink_out ()
   );

   mio_led #(
      .HOLD_CYC (HOLD_CYCLES),
      .ON_CYC   (BLINK_CYCLES),
      .ALT_CYC  (BLINK_ALT_CYCLES)
   ) u_tx_led (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .link_in   (lanes_aligned_in),
      .act_in    (tx_start_char_in),
      .alt_in    (cfg_in.tx_blink_alt),
      .led_out   (tx_led),
      .blink_out (tx_blink)
   );

   // Transmit LED mode shaping
   always_comb begin
      tx_led_lit = 1'b0;
      unique case (cfg_in.tx_led_mode)
         LED_COMBO: tx_led_lit = tx_led;
         LED_LINK:  tx_led_lit = lanes_aligned_in;
         LED_ACT:   tx_led_lit = tx_led && tx_blink;
         LED_OFF:   tx_led_lit = 1'b0;
      endcase
   end

   // Pin levels before the open-drain stage
   assign ctrl_b_lvl = (cfg_in.ctrl_b_sel ? wis_int_b_in : module_reset_in)
                       ^ cfg_in.ctrl_out_b_polarity[0]
                       ^ cfg_in.ctrl_out_b_polarity[1];
   assign alarm_lvl  = cfg_in.alarm_sel ? cfg_in.alarm_gpo_value
                       : (alarm_src_in || !cfg_in.alarm_enable);
   assign rx_lvl     = pin_level(cfg_in.rx_sel, rx_alarm_src_in, rx_led,
                                 cfg_in.rx_alarm_gpo_value);
   assign tx_lvl     = pin_level(cfg_in.tx_sel, tx_normal, tx_led_lit,
                                 cfg_in.tx_alarm_gpo_value);

   // Open-drain stage: pull low for a 0 level, else release
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         module_ctrl_out_b_oe_out <= 1'b0;
         alarm_status_oe_out      <= 1'b0;
         rx_alarm_oe_out          <= 1'b0;
         tx_alarm_oe_out          <= 1'b0;
         global_alarm_irq_oe_out  <= 1'b0;
         tx_alarm_flag_out        <= 1'b0;
      end else begin
         module_ctrl_out_b_oe_out <= !ctrl_b_lvl;
         alarm_status_oe_out      <= !alarm_lvl;
         rx_alarm_oe_out          <= !rx_lvl;
         tx_alarm_oe_out          <= !tx_lvl;
         // Interrupt line is active low: pull while the source is set or an unmasked status bit is pending
         global_alarm_irq_oe_out  <= alarm_irq_src_in
                     || |(ms_pending_out & ~cfg_in.ms_mask);
         tx_alarm_flag_out        <= tx_normal;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_ctrl_b_select;
      cfg_in.ctrl_b_sel && !wis_int_b_in && cfg_in.ctrl_out_b_polarity == 2'h0
      |=> module_ctrl_out_b_oe_out;
   endproperty
   a_ctrl_b_select: assert property (p_ctrl_b_select)
      else $error("Output B ignores interrupt B source");

   property p_ctrl_b_invert;
      !cfg_in.ctrl_b_sel && !module_reset_in
      && cfg_in.ctrl_out_b_polarity == 2'h1 |=> !module_ctrl_out_b_oe_out;
   endproperty
   a_ctrl_b_invert: assert property (p_ctrl_b_invert)
      else $error("Output B polarity not inverted");

   property p_alarm_gpo;
      cfg_in.alarm_sel
      |=> alarm_status_oe_out != $past(cfg_in.alarm_gpo_value);
   endproperty
   a_alarm_gpo: assert property (p_alarm_gpo)
      else $error("Alarm-status pin not following its value bit");

   property p_alarm_disabled;
      !cfg_in.alarm_sel && !cfg_in.alarm_enable |=> !alarm_status_oe_out;
   endproperty
   a_alarm_disabled: assert property (p_alarm_disabled)
      else $error("Alarm-status active while disabled");

   property p_rx_reserved;
      cfg_in.rx_sel == SEL_RSVD |=> !rx_alarm_oe_out;
   endproperty
   a_rx_reserved: assert property (p_rx_reserved)
      else $error("Reserved receive selector drives the pin");

   property p_rx_gpo;
      cfg_in.rx_sel == SEL_GPO
      |=> rx_alarm_oe_out == !$past(cfg_in.rx_alarm_gpo_value);
   endproperty
   a_rx_gpo: assert property (p_rx_gpo)
      else $error("Receive pin not following its value bit");

   property p_tx_gpo;
      cfg_in.tx_sel == SEL_GPO
      |=> tx_alarm_oe_out == !$past(cfg_in.tx_alarm_gpo_value);
   endproperty
   a_tx_gpo: assert property (p_tx_gpo)
      else $error("Transmit pin not following its value bit");

   property p_tx_sticky;
      tx_alarm_src_in && !cfg_in.tx_alarm_live
      ##1 (!tx_alarm_read_in && !cfg_in.tx_alarm_live) |=> tx_alarm_flag_out;
   endproperty
   a_tx_sticky: assert property (p_tx_sticky)
      else $error("Transmit alarm lost before read");

   property p_mc_override;
      cfg_in.mc_override |=> hs_master_code_out == $past(cfg_in.mc_value);
   endproperty
   a_mc_override: assert property (p_mc_override)
      else $error("Master code not taken from registers");

   property p_ms_pending;
      (pin_s2_q != ms_prev_q)
      |=> (ms_pending_out & $past(pin_s2_q ^ ms_prev_q))
          == $past(pin_s2_q ^ ms_prev_q);
   endproperty
   a_ms_pending: assert property (p_ms_pending)
      else $error("Status change did not set pending");

   property p_div64_disable;
      cfg_in.div64_disable |=> !div64_ref_out_en_out;
   endproperty
   a_div64_disable: assert property (p_div64_disable)
      else $error("Reference output not disabled");

   c_rx_led_mode: cover property (cfg_in.rx_sel == SEL_LINKACT
                                  && $rose(rx_alarm_oe_out));
   c_tx_alarm_read: cover property (tx_alarm_flag_out ##1 tx_alarm_read_in);
   c_irq_raised: cover property ($rose(global_alarm_irq_oe_out));

endmodule

// >>> testbench/mio_far.sv
// Far-side model: optical module, LEDs and host interrupt input.
// Assumes every open-drain line has a pull-up; status pins come from
// the bench, which stands in for the module's own state.
module mio_far (
   // Pull-low enables from the device
   input  wire logic [4:0] oe_in,
   // Status levels the module presents
   input  wire logic [4:0] want_in,
   // Resolved line levels
   output logic [4:0]      line_out,
   // Status pins toward the device
   output logic [2:0]      mc_pins_out,
   output logic            loss_out,
   output logic            en_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // Released lines float up through the pull-up
   assign line_out = ~oe_in;

   // Module status pins, held as the bench commands
   assign {mc_pins_out, loss_out, en_out} = want_in;
endmodule

// >>> testbench/test_mio_top.sv
// Self-checking bench for the pin multiplexer and LED logic.
// Assumes shortened LED counts: hold 20, blink 4, alternate blink 2.
module test_mio_top;
   timeunit 1ns;
   timeprecision 1ns;
   import mio_pkg::*;

   logic       clk_in, nrst_in, trd, mrst, wis, asrc, rsrc, tsrc, isrc;
   logic       lock, rxa, al, txa, boe, aoe, roe, toe, ioe;
   logic       loss_o, flag, inv_o, den, lp, ep, lb, la, lr, lt, li;
   logic [2:0] clr, mc_o, pend, lvl, mcp, pd, old, em;
   logic [4:0] want, line;
   logic [31:0] r, s;
   mio_cfg_t   cfg, c;
   int         seed = 19;
   int         mismatches = 0;
   int         num_checks = 0;

   mio_top #(.HOLD_CYCLES(20), .BLINK_CYCLES(4), .BLINK_ALT_CYCLES(2))
   mio_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .cfg_in(cfg),
      .tx_alarm_read_in(trd), .ms_pending_clr_in(clr),
      .module_reset_in(mrst), .wis_int_b_in(wis), .alarm_src_in(asrc),
      .rx_alarm_src_in(rsrc), .tx_alarm_src_in(tsrc),
      .alarm_irq_src_in(isrc), .pcs_block_lock_in(lock),
      .rx_start_char_in(rxa), .lanes_aligned_in(al),
      .tx_start_char_in(txa), .hs_master_code_pins_in(mcp),
      .optical_loss_in(lp), .div64_ref_enable_pin_in(ep),
      .module_ctrl_out_b_oe_out(boe), .alarm_status_oe_out(aoe),
      .rx_alarm_oe_out(roe), .tx_alarm_oe_out(toe),
      .global_alarm_irq_oe_out(ioe), .hs_master_code_out(mc_o),
      .ms_pending_out(pend), .ms_level_out(lvl), .optical_loss_out(loss_o),
      .tx_alarm_flag_out(flag), .serial_tx_invert_out(inv_o),
      .div64_ref_out_en_out(den));

   mio_far mio_far_i (.oe_in({boe, aoe, roe, toe, ioe}), .want_in(want),
      .line_out(line), .mc_pins_out(mcp), .loss_out(lp), .en_out(ep));

   // Free-running core clock
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // LED lit means the line is pulled low
   function automatic logic ledv(input bit tx);
      return tx ? !line[1] : !line[2];
   endfunction

   // Link up with activity: hold, blink, steady, then link down
   task automatic led(input bit tx, input int tgl, input logic lit);
      int   n;
      logic p;
      n = 0;
      @(posedge clk_in);
      if (tx) begin
         al  <= 1'b1;
         txa <= 1'b1;
      end else begin
         lock <= 1'b1;
         rxa  <= 1'b1;
      end
      repeat (2) @(posedge clk_in);
      for (int k = 0; k < 17; k++) begin
         @(negedge clk_in);
         chk(8'(ledv(tx)), 8'(lit));
      end
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      p = ledv(tx);
      repeat (16) begin
         @(negedge clk_in);
         if (ledv(tx) !== p) n++;
         p = ledv(tx);
      end
      chk(8'(n), 8'(tgl));
      @(posedge clk_in);
      rxa <= 1'b0;
      txa <= 1'b0;
      repeat (12) @(posedge clk_in);
      repeat (8) begin
         @(negedge clk_in);
         chk(8'(ledv(tx)), 8'(lit));
      end
      @(posedge clk_in);
      lock <= 1'b0;
      al   <= 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk(8'(ledv(tx)), 8'h00);
   endtask

   // Hang guard, well past the expected run length
   initial begin
      repeat (4000) @(posedge clk_in);
      mismatches++;
      test_done();
   end

   // Main sequence
   initial begin
      nrst_in = 1'b0;
      cfg = '0;
      {trd, clr, mrst, wis, asrc, rsrc, tsrc, isrc} = '0;
      {lock, rxa, al, txa} = '0;
      want = 5'h01;
      pd = '0;
      old = '0;
      repeat (8) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      // Low sources pull B, rx and tx; alarm-status and irq stay released
      chk({3'h0, line}, 8'h09);
      chk({pend, mc_o, den}, 8'h01);
      // Random selectors, sources and module pins
      for (int i = 0; i < 150; i++) begin
         r = $random(seed);
         s = $random(seed);
         c = mio_cfg_t'(r[24:0]);
         if (c.rx_sel == SEL_LINKACT) c.rx_sel = SEL_GPO;
         if (c.tx_sel == SEL_LINKACT) c.tx_sel = SEL_NORMAL;
         // Live alarm keeps the normal tx level a plain copy of its source
         c.tx_alarm_live = 1'b1;
         @(posedge clk_in);
         cfg <= c;
         {mrst, wis, asrc, rsrc, tsrc, isrc} <= s[5:0];
         want <= s[10:6];
         repeat (4) @(posedge clk_in);
         @(negedge clk_in);
         pd = pd | (s[10:8] ^ old);
         old = s[10:8];
         lb = (c.ctrl_b_sel ? s[4] : s[5]) ^ c.ctrl_out_b_polarity[0]
            ^ c.ctrl_out_b_polarity[1];
         la = c.alarm_sel ? c.alarm_gpo_value : (s[3] | !c.alarm_enable);
         lr = (c.rx_sel == SEL_GPO) ? c.rx_alarm_gpo_value
            : ((c.rx_sel == SEL_RSVD) ? 1'b1 : s[2]);
         lt = (c.tx_sel == SEL_GPO) ? c.tx_alarm_gpo_value
            : ((c.tx_sel == SEL_RSVD) ? 1'b1 : s[1]);
         li = !(s[0] | (|(pd & ~c.ms_mask)));
         em = c.mc_override ? c.mc_value : s[10:8];
         chk(8'(line[4]), 8'(lb));
         chk(8'(line[3]), 8'(la));
         chk(8'(line[2]), 8'(lr));
         chk(8'(line[1]), 8'(lt));
         chk(8'(line[0]), 8'(li));
         chk(8'(flag), 8'(s[1]));
         chk({5'h0, mc_o}, {5'h0, em});
         chk({2'h0, pend, lvl}, {2'h0, pd, s[10:8]});
         chk({5'h0, loss_o, inv_o, den},
             {5'h0, s[7], c.serial_tx_invert, s[6] & !c.div64_disable});
      end
      // Pending clear with pins steady
      @(posedge clk_in);
      clr <= 3'h7;
      @(posedge clk_in);
      clr <= 3'h0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk({5'h0, pend}, 8'h00);
      // Transmit alarm latch, clear on read, set wins
      c = '0;
      @(posedge clk_in);
      cfg <= c;
      {tsrc, trd} <= 2'b01;
      @(posedge clk_in);
      {tsrc, trd} <= 2'b10;
      @(posedge clk_in);
      {tsrc, trd} <= 2'b00;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk({7'h0, flag}, 8'h01);
      @(posedge clk_in);
      {tsrc, trd} <= 2'b11;
      @(posedge clk_in);
      {tsrc, trd} <= 2'b00;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk({7'h0, flag}, 8'h01);
      @(posedge clk_in);
      trd <= 1'b1;
      @(posedge clk_in);
      trd <= 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk({7'h0, flag}, 8'h00);
      c.tx_alarm_live = 1'b1;
      @(posedge clk_in);
      cfg <= c;
      tsrc <= 1'b1;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk({7'h0, flag}, 8'h01);
      // LED behaviour on both pins and all transmit modes
      c = '0;
      c.rx_sel = SEL_LINKACT;
      @(posedge clk_in);
      cfg <= c;
      tsrc <= 1'b0;
      led(1'b0, 4, 1'b1);
      @(posedge clk_in);
      c.rx_sel = SEL_NORMAL;
      c.tx_sel = SEL_LINKACT;
      c.tx_blink_alt = 1'b1;
      cfg <= c;
      led(1'b1, 8, 1'b1);
      @(posedge clk_in);
      c.tx_led_mode = LED_LINK;
      cfg <= c;
      led(1'b1, 0, 1'b1);
      // Activity mode: dark in hold and steady, lit only in blink phase
      @(posedge clk_in);
      c.tx_led_mode = LED_ACT;
      cfg <= c;
      led(1'b1, 8, 1'b0);
      @(posedge clk_in);
      c.tx_led_mode = LED_OFF;
      cfg <= c;
      led(1'b1, 0, 1'b0);
      test_done();
   end
endmodule
